/* File: hdl/serial_port_pkg.sv */
// Shared constants for the asynchronous serial port, framing modes 1-3.
// Assumes one system clock; timer overflows arrive as one-cycle pulses.
package serial_port_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Mode codes {mode_select_high, mode_select_low}
  localparam logic [1:0] MODE_SHIFT   = 2'h0;
  localparam logic [1:0] MODE_TEN_BIT = 2'h1;
  localparam logic [1:0] MODE_FIXED   = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Widths and depths
  localparam int          DATA_WIDTH    = 8;
  localparam int          TX_FIFO_DEPTH = 32;

  ////////////////////////////////////////////////////////////////////////
  // Bit-time counter: sixteen states, samples in states 6, 7 and 8
  localparam logic [3:0] BIT_LAST_STATE = 4'hf;
  localparam logic [3:0] SAMPLE_FIRST   = 4'h6;
  localparam logic [3:0] SAMPLE_MID     = 4'h7;
  localparam logic [3:0] SAMPLE_LAST    = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Shift register values
  localparam logic [8:0] RX_SHIFT_PRESET = 9'h1ff;
  localparam logic [8:0] SHIFT_CLEAR     = 9'h000;
  localparam logic [7:0] TX_END_MARK     = 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // Fixed-rate prescaler: 16x tick every 4 clocks, or every 2 if doubled
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] PRESCALE_RST  = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic       LINE_IDLE  = 1'b1;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [2:0] SAMPLE_RST = 3'h0;

endpackage : serial_port_pkg

/* File: hdl/tx_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/100ps
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                 (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push  = i_in_valid && !full;
  assign pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule : tx_fifo

/* File: hdl/serial_port.sv */
// Asynchronous serial port, modes 1 (10-bit) and 2/3 (11-bit frames).
// Assumes timer overflow pulses are on I_CLK; the receive pin is async.
// Control and status bits are plain ports; flags clear by pulse inputs.
`timescale 1ns/100ps
module serial_port
  import serial_port_pkg::*;
#(
  parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RSTN,
  // Serial lines
  input  wire logic       I_RXD,
  output logic            O_TXD,
  // Mode and configuration bits
  input  wire logic       I_MODE_SELECT_HIGH,
  input  wire logic       I_MODE_SELECT_LOW,
  input  wire logic       I_MULTIPROC_FILTER,
  input  wire logic       I_RX_ENABLE_BIT,
  input  wire logic       I_TX_NINTH_BIT,
  input  wire logic       I_BAUD_DOUBLER,
  input  wire logic       I_TX_TIMER2_SELECT,
  input  wire logic       I_RX_TIMER2_SELECT,
  // Timer overflow pulses
  input  wire logic       I_TIMER1_OVF,
  input  wire logic       I_TIMER2_OVF,
  // Transmit data writes
  input  wire logic       I_TX_WRITE,
  input  wire logic [7:0] I_TX_DATA,
  output logic            O_TX_READY,
  // Receive buffer and flags
  output logic [7:0]      O_TX_RX_BUFFER,
  output logic            O_RX_NINTH_BIT,
  output logic            O_RX_DONE_FLAG,
  output logic            O_TX_DONE_FLAG,
  input  wire logic       I_RX_DONE_CLR,
  input  wire logic       I_TX_DONE_CLR,
  // Status
  output logic            O_TX_ACTIVE,
  output logic            O_RX_BUSY
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic pick_tick(
    input logic [1:0] mode,
    input logic       t2_sel,
    input logic       fixed_tick,
    input logic       t1_tick,
    input logic       t2_tick
  );
    logic t;
    t = 1'b0;
    if (mode == MODE_FIXED) begin
      t = fixed_tick;
    end else if (mode != MODE_SHIFT) begin
      t = t2_sel ? t2_tick : t1_tick;
    end
    return t;
  endfunction : pick_tick

  function automatic logic [7:0] reverse8(input logic [7:0] v);
    logic [7:0] r;
    r = DATA_RST;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : reverse8

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT,
    TX_START,
    TX_DATA
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_BITS,
    RX_TAIL
  } rx_state_e;

  logic [1:0] mode;
  logic       eleven_bit;

  assign mode       = {I_MODE_SELECT_HIGH, I_MODE_SELECT_LOW};
  assign eleven_bit = I_MODE_SELECT_HIGH;

  ////////////////////////////////////////////////////////////////////////
  // Baud tick generation

  logic [1:0] prescale_reg;
  logic       t1_half_reg;
  logic       fixed_tick;
  logic       t1_tick;
  logic       tx_tick;
  logic       rx_tick;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prescale_reg <= PRESCALE_RST;
    end else begin
      prescale_reg <= prescale_reg + 2'h1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      t1_half_reg <= 1'b0;
    end else if (I_TIMER1_OVF) begin
      t1_half_reg <= !t1_half_reg;
    end
  end

  // 16x tick: osc/4 normally, osc/2 doubled
  assign fixed_tick = I_BAUD_DOUBLER ? prescale_reg[0]
                                     : (prescale_reg == PRESCALE_LAST);
  // Every other overflow unless doubled
  assign t1_tick = I_TIMER1_OVF && (I_BAUD_DOUBLER || t1_half_reg);

  assign tx_tick = pick_tick(mode, I_TX_TIMER2_SELECT, fixed_tick,
                             t1_tick, I_TIMER2_OVF);
  assign rx_tick = pick_tick(mode, I_RX_TIMER2_SELECT, fixed_tick,
                             t1_tick, I_TIMER2_OVF);

  ////////////////////////////////////////////////////////////////////////
  // Transmit FIFO

  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;

  tx_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_in_valid  (I_TX_WRITE),
    .i_in_data   (I_TX_DATA),
    .o_in_ready  (O_TX_READY),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmitter

  tx_state_e  tx_state_reg;
  logic [3:0] tx_cnt_reg;
  logic [8:0] tx_shift_reg;
  logic       tx_shifted_reg;
  logic       tx_done_reg;
  logic       txd_reg;
  logic       tx_roll;
  logic       tx_final;

  assign fifo_pop = (tx_state_reg == TX_IDLE) && fifo_valid &&
                    (mode != MODE_SHIFT);
  assign tx_roll  = tx_tick && (tx_cnt_reg == BIT_LAST_STATE);
  assign tx_final = tx_shifted_reg &&
                    (tx_shift_reg[8:1] == TX_END_MARK);

  // Free-running divide-by-16; bit times follow its rollovers
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_cnt_reg <= 4'h0;
    end else if (tx_tick) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_state_reg   <= TX_IDLE;
      tx_shift_reg   <= SHIFT_CLEAR;
      tx_shifted_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (fifo_pop) begin
            // Ninth position: stop one, or the programmed ninth bit
            tx_shift_reg   <= {eleven_bit ? I_TX_NINTH_BIT : 1'b1,
                               fifo_data};
            tx_shifted_reg <= 1'b0;
            tx_state_reg   <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_roll) begin
            tx_state_reg <= TX_START;
          end
        end
        TX_START: begin
          if (tx_roll) begin
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_roll) begin
            tx_shifted_reg <= 1'b1;
            if (!tx_shifted_reg && eleven_bit) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            end else begin
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            end
            if (tx_final) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Line: start low, then shifter output, high otherwise
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      txd_reg <= LINE_IDLE;
    end else begin
      case (tx_state_reg)
        TX_START: txd_reg <= 1'b0;
        TX_DATA:  txd_reg <= tx_shift_reg[0];
        default:  txd_reg <= LINE_IDLE;
      endcase
    end
  end

  // Done flag: set wins over clear
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_done_reg <= 1'b0;
    end else if ((tx_state_reg == TX_DATA) && tx_roll && tx_final) begin
      tx_done_reg <= 1'b1;
    end else if (I_TX_DONE_CLR) begin
      tx_done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser and edge detector

  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic rxd_prev_reg;
  logic rxd_fall;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rxd_meta_reg <= LINE_IDLE;
      rxd_sync_reg <= LINE_IDLE;
      rxd_prev_reg <= LINE_IDLE;
    end else begin
      rxd_meta_reg <= I_RXD;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
    end
  end

  assign rxd_fall = rxd_prev_reg && !rxd_sync_reg;

  ////////////////////////////////////////////////////////////////////////
  // Receiver

  rx_state_e  rx_state_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] rx_samp_reg;
  logic [8:0] rx_shift_reg;
  logic       rx_first_reg;
  logic       rx_roll;
  logic       rx_bit;
  logic       rx_start;
  logic       rx_last;
  logic       rx_accept;
  logic       rx_load;
  logic [7:0] rx_buf_reg;
  logic       rx_ninth_reg;
  logic       rx_done_reg;

  assign rx_start = (rx_state_reg == RX_IDLE) && rxd_fall &&
                    I_RX_ENABLE_BIT && (mode != MODE_SHIFT);
  assign rx_roll  = rx_tick && (rx_cnt_reg == BIT_LAST_STATE);
  // Two of three samples decide
  assign rx_bit   = (rx_samp_reg[0] & rx_samp_reg[1]) |
                    (rx_samp_reg[1] & rx_samp_reg[2]) |
                    (rx_samp_reg[0] & rx_samp_reg[2]);
  // Start bit reached the leftmost position
  assign rx_last  = !rx_shift_reg[8];
  // Final bit is stop in 10-bit mode, ninth bit otherwise
  assign rx_accept = (!I_MULTIPROC_FILTER || rx_bit) &&
                     !rx_done_reg;
  assign rx_load  = (rx_state_reg == RX_BITS) && rx_roll &&
                    !rx_first_reg && rx_last && rx_accept;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_cnt_reg <= 4'h0;
    end else if (rx_start) begin
      rx_cnt_reg <= 4'h0;
    end else if (rx_tick) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
    end
  end

  // Samples in the 7th, 8th and 9th counter states
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_samp_reg <= SAMPLE_RST;
    end else if (rx_tick) begin
      case (rx_cnt_reg)
        SAMPLE_FIRST: rx_samp_reg[0] <= rxd_sync_reg;
        SAMPLE_MID:   rx_samp_reg[1] <= rxd_sync_reg;
        SAMPLE_LAST:  rx_samp_reg[2] <= rxd_sync_reg;
        default:      rx_samp_reg    <= rx_samp_reg;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= RX_SHIFT_PRESET;
      rx_first_reg <= 1'b0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_start) begin
            rx_shift_reg <= RX_SHIFT_PRESET;
            rx_first_reg <= 1'b1;
            rx_state_reg <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_roll) begin
            rx_first_reg <= 1'b0;
            if (rx_first_reg && rx_bit) begin
              rx_state_reg <= RX_IDLE;
            end else if (!rx_first_reg && rx_last) begin
              rx_shift_reg <= RX_SHIFT_PRESET;
              // 11-bit frames let the stop bit pass unchecked
              rx_state_reg <= eleven_bit ? RX_TAIL
                                         : RX_IDLE;
            end else begin
              rx_shift_reg <= {rx_shift_reg[7:0], rx_bit};
            end
          end
        end
        RX_TAIL: begin
          if (rx_roll) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Buffer and ninth bit load only when the frame is accepted
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_buf_reg   <= DATA_RST;
      rx_ninth_reg <= 1'b0;
    end else if (rx_load) begin
      rx_buf_reg   <= reverse8(rx_shift_reg[7:0]);
      rx_ninth_reg <= rx_bit;
    end
  end

  // Done flag: set wins over clear
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_done_reg <= 1'b0;
    end else if (rx_load) begin
      rx_done_reg <= 1'b1;
    end else if (I_RX_DONE_CLR) begin
      rx_done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_TXD          = txd_reg;
  assign O_TX_RX_BUFFER = rx_buf_reg;
  assign O_RX_NINTH_BIT = rx_ninth_reg;
  assign O_RX_DONE_FLAG = rx_done_reg;
  assign O_TX_DONE_FLAG = tx_done_reg;
  assign O_TX_ACTIVE    = (tx_state_reg == TX_START) ||
                          (tx_state_reg == TX_DATA);
  assign O_RX_BUSY      = (rx_state_reg != RX_IDLE);

endmodule : serial_port

/* File: tb/serial_port_sva.sv */
// Checker on the serial port's own pins, bound into every serial_port.
// Assumes one clock and the active-low asynchronous reset of the block.
`timescale 1ns/100ps
module serial_port_sva (
  // Clock and reset
  input wire logic       I_CLK,
  input wire logic       I_RSTN,
  // Watched inputs
  input wire logic       I_RX_ENABLE_BIT,
  input wire logic       I_RX_DONE_CLR,
  input wire logic       I_TX_DONE_CLR,
  // Watched outputs
  input wire logic       O_TXD,
  input wire logic [7:0] O_TX_RX_BUFFER,
  input wire logic       O_RX_NINTH_BIT,
  input wire logic       O_RX_DONE_FLAG,
  input wire logic       O_TX_DONE_FLAG,
  input wire logic       O_TX_ACTIVE,
  input wire logic       O_RX_BUSY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  AST_TX_IDLE_HIGH: assert property (
    !O_TX_ACTIVE && !$past(O_TX_ACTIVE) |-> O_TXD)
    else $error("transmit line low outside a frame");
  AST_TX_START_LOW: assert property (
    $rose(O_TX_ACTIVE) |-> ##[0:1] !O_TXD [*8])
    else $error("start bit missing or short");
  AST_TX_DONE_AT_END: assert property (
    $fell(O_TX_ACTIVE) |-> ##[0:1] O_TX_DONE_FLAG)
    else $error("transmit done not set at frame end");
  AST_TX_DONE_HOLD: assert property (
    O_TX_DONE_FLAG && !I_TX_DONE_CLR |=> O_TX_DONE_FLAG)
    else $error("transmit done dropped without clear");
  AST_RX_DONE_HOLD: assert property (
    O_RX_DONE_FLAG && !I_RX_DONE_CLR |=> O_RX_DONE_FLAG)
    else $error("receive done dropped without clear");
  AST_RX_LOCKED: assert property (
    O_RX_DONE_FLAG |=> $stable(O_TX_RX_BUFFER) && $stable(O_RX_NINTH_BIT))
    else $error("buffer changed while receive done set");
  AST_LOAD_WITH_FLAG: assert property (
    $changed(O_TX_RX_BUFFER) || $changed(O_RX_NINTH_BIT)
      |-> $rose(O_RX_DONE_FLAG))
    else $error("buffer loaded without raising receive done");
  AST_RX_DISABLED_IDLE: assert property (
    !I_RX_ENABLE_BIT && !O_RX_BUSY |=> !O_RX_BUSY)
    else $error("reception started while disabled");

  cover property ($rose(O_RX_DONE_FLAG));
  cover property ($fell(O_TX_ACTIVE));
  cover property ($fell(O_RX_BUSY) && !O_RX_DONE_FLAG);
endmodule : serial_port_sva

////////////////////////////////////////////////////////////////////////////
bind serial_port serial_port_sva chk (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_RX_ENABLE_BIT(I_RX_ENABLE_BIT),
  .I_RX_DONE_CLR(I_RX_DONE_CLR), .I_TX_DONE_CLR(I_TX_DONE_CLR),
  .O_TXD(O_TXD), .O_TX_RX_BUFFER(O_TX_RX_BUFFER),
  .O_RX_NINTH_BIT(O_RX_NINTH_BIT), .O_RX_DONE_FLAG(O_RX_DONE_FLAG),
  .O_TX_DONE_FLAG(O_TX_DONE_FLAG), .O_TX_ACTIVE(O_TX_ACTIVE),
  .O_RX_BUSY(O_RX_BUSY)
);

/* File: tb/serial_node.sv */
// Remote serial node: sends frames to the block, captures what it sends.
// Assumes the bench sets bit length in clocks and frame size beforehand.
`timescale 1ns/100ps
module serial_node (
  // Clock
  input  wire logic clk,
  // Serial lines seen from the remote side
  input  wire logic txd_in,
  output logic      rxd_out
);
  int         bit_clks = 64;
  logic       nine     = 1'b1;
  logic [9:0] got[$];

  initial rxd_out = 1'b1;

  // Start low, data lsb first, ninth or stop, then high
  task automatic send(input logic [7:0] d, input logic b9);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};
    for (int i = 0; i < 10 + int'(nine); i++) begin
      @(negedge clk);
      rxd_out = f[i];
      repeat (bit_clks - 1) @(negedge clk);
    end
    @(negedge clk);
    rxd_out = 1'b1;
    repeat (bit_clks) @(negedge clk);
  endtask : send

  task automatic glitch(input int n);
    @(negedge clk);
    rxd_out = 1'b0;
    repeat (n) @(negedge clk);
    rxd_out = 1'b1;
  endtask : glitch

  ////////////////////////////////////////////////////////////////////////
  // Capture {stop, ninth, data}; ten-bit frames repeat the stop bit
  always begin
    logic [9:0] v;
    @(negedge txd_in);
    repeat (bit_clks / 2) @(posedge clk);
    v = 10'h000;
    for (int i = 0; i < 9 + int'(nine); i++) begin
      repeat (bit_clks) @(posedge clk);
      v = {txd_in, v[9:1]};
    end
    if (!nine) v = {v[9], v[9:1]};
    got.push_back(v);
  end
endmodule : serial_node

/* File: tb/serial_port_test.sv */
// Bench for serial_port: rates, framing, receive gating and FIFO fill.
// Assumes the node model and the checker are compiled alongside.
`timescale 1ns/100ps
module serial_port_test;
  import serial_port_pkg::*;

  typedef struct {
    logic [1:0] m;
    bit         d, t2, f, b9, clr;
    int         bc;
  } cfg_s;

  // Mode, doubler, timer2, filter, ninth, clear, clocks per bit
  cfg_s tx_tab [6] = '{'{MODE_FIXED, 0, 0, 0, 0, 0, 64},
    '{MODE_FIXED, 1, 0, 0, 1, 0, 32}, '{MODE_TEN_BIT, 0, 0, 0, 1, 0, 160},
    '{MODE_TEN_BIT, 0, 1, 0, 1, 0, 48}, '{MODE_TIMER, 1, 0, 0, 1, 0, 80},
    '{MODE_TIMER, 0, 1, 0, 0, 0, 48}};
  cfg_s rx_tab [7] = '{'{MODE_TEN_BIT, 1, 1, 1, 0, 0, 48},
    '{MODE_TEN_BIT, 1, 1, 1, 1, 0, 48}, '{MODE_FIXED, 1, 0, 0, 1, 0, 32},
    '{MODE_TIMER, 1, 0, 1, 0, 1, 80}, '{MODE_TIMER, 1, 0, 1, 1, 0, 80},
    '{MODE_FIXED, 0, 0, 0, 0, 1, 64}, '{MODE_TEN_BIT, 0, 1, 0, 0, 1, 48}};

  logic       clk = 1'b0, rstn = 1'b0, mode_hi = 1'b0, mode_lo = 1'b0;
  logic       filter = 1'b0, rx_en = 1'b0, ninth = 1'b0, doubler = 1'b0;
  logic       tx_t2 = 1'b0, rx_t2 = 1'b0, t1_ovf = 1'b0, t2_ovf = 1'b0;
  logic       wr = 1'b0, rx_clr = 1'b0, tx_clr = 1'b0;
  logic [7:0] wdata = 8'h00, buffer;
  logic       txd, rxd, ready, rx_ninth, rx_done, tx_done, active, busy;
  int         miscompares = 0, n_compared = 0, tcnt = 0;

  always #4 clk = ~clk;

  // Timer 1 overflows every 5 clocks, timer 2 every 3
  // Timer 1 as fixed-period reload source; no interrupt model
  always @(negedge clk) begin
    tcnt   <= tcnt + 1;
    t1_ovf <= (tcnt % 5 == 0);
    t2_ovf <= (tcnt % 3 == 0);
  end

  serial_port dut (.I_CLK(clk), .I_RSTN(rstn), .I_RXD(rxd), .O_TXD(txd),
    .I_MODE_SELECT_HIGH(mode_hi), .I_MODE_SELECT_LOW(mode_lo),
    .I_MULTIPROC_FILTER(filter), .I_RX_ENABLE_BIT(rx_en),
    .I_TX_NINTH_BIT(ninth), .I_BAUD_DOUBLER(doubler),
    .I_TX_TIMER2_SELECT(tx_t2), .I_RX_TIMER2_SELECT(rx_t2),
    .I_TIMER1_OVF(t1_ovf), .I_TIMER2_OVF(t2_ovf), .I_TX_WRITE(wr),
    .I_TX_DATA(wdata), .O_TX_READY(ready), .O_TX_RX_BUFFER(buffer),
    .O_RX_NINTH_BIT(rx_ninth), .O_RX_DONE_FLAG(rx_done),
    .O_TX_DONE_FLAG(tx_done), .I_RX_DONE_CLR(rx_clr),
    .I_TX_DONE_CLR(tx_clr), .O_TX_ACTIVE(active), .O_RX_BUSY(busy));

  serial_node node (.clk(clk), .txd_in(txd), .rxd_out(rxd));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 40000; k++) begin
      if (node.got.size() >= n) break;
      @(negedge clk);
    end
    if (k == 40000) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_got

  task automatic set_cfg(input cfg_s c, input bit rx);
    @(negedge clk);
    {mode_hi, mode_lo} = c.m;
    doubler = c.d;
    filter = c.f;
    if (rx) rx_t2 = c.t2;
    else tx_t2 = c.t2;
    node.bit_clks = c.bc;
    node.nine = c.m[1];
  endtask : set_cfg

  task automatic clear(input bit rx);
    @(negedge clk);
    rx_clr = rx;
    tx_clr = !rx;
    @(negedge clk);
    rx_clr = 1'b0;
    tx_clr = 1'b0;
  endtask : clear

  task automatic write_byte(input logic [7:0] d);
    @(negedge clk);
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : write_byte

  function automatic logic [9:0] pins();
    return {txd, ready, rx_done, tx_done, active, busy, rx_ninth, 2'h0,
            |buffer};
  endfunction : pins

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    check("pins in reset", 10'h300, pins());
    rstn = 1'b1;
    @(negedge clk);
    check("pins after reset", 10'h300, pins());
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////
  task automatic t_tx_rates();
    logic [9:0] exp;
    for (int i = 0; i < 6; i++) begin
      set_cfg(tx_tab[i], 1'b0);
      ninth = tx_tab[i].b9;
      clear(1'b0);
      node.got.delete();
      exp = {1'b1, tx_tab[i].m[1] ? tx_tab[i].b9 : 1'b1, 8'ha5 ^ 8'(i)};
      write_byte(exp[7:0]);
      wait_got(1);
      check("tx frame", exp, node.got[0]);
      check("tx done", 10'h001, {9'h000, tx_done});
    end
  endtask : t_tx_rates

  task automatic t_rx_cases();
    logic [9:0] exp;
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      set_cfg(rx_tab[i], 1'b1);
      if (rx_tab[i].clr) clear(1'b1);
      d = 8'h96 + 8'(i) * 8'h25;
      exp = {rx_done, rx_ninth, buffer};
      if ((!rx_tab[i].f || rx_tab[i].b9) && rx_done === 1'b0)
        exp = {1'b1, rx_tab[i].b9, d};
      node.send(d, rx_tab[i].b9);
      check("rx frame", exp, {rx_done, rx_ninth, buffer});
    end
  endtask : t_rx_cases

  task automatic t_rx_guard();
    logic [9:0] was;
    set_cfg(rx_tab[2], 1'b1);
    clear(1'b1);
    was = {rx_done, rx_ninth, buffer};
    rx_en = 1'b0;
    node.send(8'h42, 1'b1);
    check("rx disabled", was, {rx_done, rx_ninth, buffer});
    rx_en = 1'b1;
    node.glitch(6);
    repeat (64) @(negedge clk);
    check("false start", was, {rx_done, rx_ninth, buffer});
    check("rx busy", 10'h000, {9'h000, busy});
    node.send(8'hc3, 1'b0);
    check("rx after", 10'h2c3, {rx_done, rx_ninth, buffer});
  endtask : t_rx_guard

  task automatic t_fifo();
    int n;
    @(negedge clk);
    {mode_hi, mode_lo} = MODE_SHIFT;
    ninth = 1'b1;
    node.got.delete();
    wr = 1'b1;
    for (n = 0; n < 40; n++) begin
      wdata = 8'(n);
      @(negedge clk);
      if (ready !== 1'b1) break;
    end
    wdata = 8'hee;
    @(negedge clk);
    wr = 1'b0;
    check("fifo depth", 10'h020, 10'(n + 1));
    set_cfg(tx_tab[1], 1'b0);
    wait_got(32);
    for (int i = 0; i < 32; i++)
      check("fifo frame", {2'h3, 8'(i)}, node.got[i]);
    repeat (800) @(negedge clk);
    check("frame count", 10'h020, 10'(node.got.size()));
  endtask : t_fifo

  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rx_en = 1'b1;
    t_tx_rates();
    t_rx_cases();
    t_rx_guard();
    t_fifo();
    write_byte(8'h5a);
    repeat (100) @(negedge clk);
    do_reset();
    stop_test();
  end
endmodule : serial_port_test
